// file: design/spcp_params.svh
// timing and field constants for the single pin programmer
`ifndef SPCP_PARAMS_SVH
`define SPCP_PARAMS_SVH
`define SPCP_CLK_HZ        25000000
`define SPCP_BIT_HZ        70000
`define SPCP_BIT_CYC       (`SPCP_CLK_HZ / `SPCP_BIT_HZ)
`define SPCP_SHORT_CYC     (`SPCP_BIT_CYC / 5)
`define SPCP_LONG_CYC      ((`SPCP_BIT_CYC * 4) / 5)
`define SPCP_HALF_CYC      (`SPCP_BIT_CYC / 2)
`define SPCP_TIMEOUT_MS    16
`define SPCP_TIMEOUT_CYC   ((`SPCP_CLK_HZ / 1000) * `SPCP_TIMEOUT_MS)
`define SPCP_EE_WAIT_MS    10
`define SPCP_EE_WAIT_CYC   ((`SPCP_CLK_HZ / 1000) * `SPCP_EE_WAIT_MS)
`define SPCP_ENTRY_LEN     6
`define SPCP_CMD_LEN       10
`define SPCP_ENTER_PROG    6'h0C
`define SPCP_ENTER_READ    6'h3B
`define SPCP_SEL_JUMP      3'h7
`define SPCP_JUMP_EE       8'hF0
`define SPCP_JUMP_EE_LOCK  8'h55
`define SPCP_JUMP_EXIT     8'h00
`define SPCP_NUM_WORDS     6
`endif

// file: design/spcp_pkg.sv
// shared types for the single pin programmer
package spcp_pkg;
  typedef enum logic [2:0] {
    SPCP_NORMAL, SPCP_PROG, SPCP_EE_STORE, SPCP_EE_LOCK, SPCP_READBACK
  } spcp_state_t;
  typedef logic [7:0] spcp_word_t;
endpackage

// file: design/spcp_link_if.sv
// single programming pin between host and device
`timescale 1ns/1ps
interface spcp_link_if;
  logic serial_program_pin;
  modport device (input serial_program_pin);
  modport host   (output serial_program_pin);
endinterface

// file: design/spcp_device.sv
// device end: decodes pulse-coded commands on the programming pin
// What this block does
// - 001100 enters programming mode from normal
// - 111011 enters readback mode from normal
// - three-bit selector picks config word zero..five
// - tenth bit latches word, applied immediately
// - one bit captured per falling pin edge
// - idle gaps inside word write tolerated
// - 111 1111 0000 jumps to store
// - 111 0101 0101 jumps to store and lock
// - 111 0000 0000 leaves store states
// - other 111 commands exit to normal
// - pin is input only, readback elsewhere
// - host tracks writes when no readback
// - feedback divider follows prescaler setting
// - host sends pulse-coded, not clocked, data
// - short high is 0, long is 1
// - entry pulses must end within 16 ms
// - chip enable ignored outside normal state
// - host waits 10 ms after store jump
`timescale 1ns/1ps
`include "spcp_params.svh"
module spcp_device (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                reset,
  input  wire logic                clock_enable,
  // link
  spcp_link_if.device              link,
  // user side
  input  wire logic                chip_enable,
  input  wire logic [2:0]          prescaler,
  output logic      [47:0]         config_words,
  output logic      [5:0]          feedback_div,
  output spcp_pkg::spcp_state_t    state,
  output logic                     outputs_enabled,
  output logic                     store_request,
  output logic                     store_lock,
  output logic                     readback_active
);
  // pin synchroniser, first stage read only by second
  logic                  pin_s1_q, pin_s2_q, pin_prev_q;
  logic [15:0]           high_cnt_q;
  logic [19:0]           idle_cnt_q;
  logic [9:0]            bits_q;
  logic [3:0]            nbits_q;
  logic [7:0]            words_q [`SPCP_NUM_WORDS];
  spcp_pkg::spcp_state_t state_q;
  logic                  rise, fall, bit_val, timeout;
  logic [9:0]            cmd;

  function automatic logic [5:0] fb_of(input logic [2:0] p);
    case (p)
      3'h2:    fb_of = 6'h20;
      3'h3:    fb_of = 6'h14;
      3'h4:    fb_of = 6'h10;
      3'h5:    fb_of = 6'h0C;
      default: fb_of = 6'h00;
    endcase
  endfunction

  // selector sent lsb-first: 000,100,010,110,001,101 name words 0..5;
  // its third slot doubles as the payload msb
  function automatic logic [2:0] widx(input logic [9:0] c);
    widx = {c[7], c[8], c[9]};
  endfunction

  // third slot is 1 in every jump; seven bits tell them apart
  function automatic logic jump_is(input logic [9:0] c,
                                   input logic [7:0] code);
    jump_is = (c[6:0] == code[6:0]);
  endfunction

  always_ff @(posedge clock) begin
    if (reset) begin
      pin_s1_q   <= 1'b0;
      pin_s2_q   <= 1'b0;
      pin_prev_q <= 1'b0;
    end else if (clock_enable) begin
      pin_s1_q   <= link.serial_program_pin;
      pin_s2_q   <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  assign rise = pin_s2_q & ~pin_prev_q;
  assign fall = ~pin_s2_q & pin_prev_q;
  // long high pulse means 1, threshold halfway
  assign bit_val = (high_cnt_q >= 16'(`SPCP_HALF_CYC));
  assign cmd = {bits_q[8:0], bit_val};
  // gaps only time out entry sequences in normal state
  assign timeout = (state_q == spcp_pkg::SPCP_NORMAL) && (nbits_q != 4'h0)
                   && (idle_cnt_q >= 20'(`SPCP_TIMEOUT_CYC));

  // pulse width, sampled at the falling edge
  always_ff @(posedge clock) begin
    if (reset) begin
      high_cnt_q <= 16'h0000;
    end else if (clock_enable) begin
      if (rise) begin
        high_cnt_q <= 16'h0000;
      end else if (pin_s2_q && high_cnt_q != 16'hFFFF) begin
        high_cnt_q <= high_cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      idle_cnt_q <= 20'h00000;
    end else if (clock_enable) begin
      if (rise || fall) begin
        idle_cnt_q <= 20'h00000;
      end else if (idle_cnt_q != 20'hFFFFF) begin
        idle_cnt_q <= idle_cnt_q + 20'h00001;
      end
    end
  end

  // bit assembly and state transitions, bit decided on fall
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= spcp_pkg::SPCP_NORMAL;
      bits_q  <= 10'h000;
      nbits_q <= 4'h0;
      for (int i = 0; i < `SPCP_NUM_WORDS; i++) words_q[i] <= 8'h00;
    end else if (clock_enable) begin
      if (timeout) begin
        bits_q  <= 10'h000;
        nbits_q <= 4'h0;
      end else if (fall) begin
        bits_q  <= cmd;
        nbits_q <= nbits_q + 4'h1;
        case (state_q)
          spcp_pkg::SPCP_NORMAL: begin
            if (nbits_q == 4'(`SPCP_ENTRY_LEN - 1)) begin
              nbits_q <= 4'h0;
              if (cmd[5:0] == `SPCP_ENTER_PROG) begin
                state_q <= spcp_pkg::SPCP_PROG;
              end else if (cmd[5:0] == `SPCP_ENTER_READ) begin
                state_q <= spcp_pkg::SPCP_READBACK;
              end
            end
          end
          spcp_pkg::SPCP_PROG, spcp_pkg::SPCP_EE_STORE,
          spcp_pkg::SPCP_EE_LOCK: begin
            if (nbits_q == 4'(`SPCP_CMD_LEN - 1)) begin
              nbits_q <= 4'h0;
              if (cmd[9:7] != `SPCP_SEL_JUMP) begin
                // selector 011 names no word and is dropped
                if (state_q == spcp_pkg::SPCP_PROG
                    && widx(cmd) < 3'(`SPCP_NUM_WORDS)) begin
                  words_q[widx(cmd)] <= cmd[7:0];
                end
              end else if (state_q == spcp_pkg::SPCP_PROG
                           && jump_is(cmd, `SPCP_JUMP_EE)) begin
                state_q <= spcp_pkg::SPCP_EE_STORE;
              end else if (state_q == spcp_pkg::SPCP_PROG
                           && jump_is(cmd, `SPCP_JUMP_EE_LOCK)) begin
                state_q <= spcp_pkg::SPCP_EE_LOCK;
              end else begin
                state_q <= spcp_pkg::SPCP_NORMAL;
              end
            end
          end
          default: begin
            // readback stream lies outside this block
            nbits_q <= 4'h0;
          end
        endcase
      end
    end
  end

  // word n drives bits 8n+7:8n
  always_comb begin
    for (int i = 0; i < `SPCP_NUM_WORDS; i++) begin
      config_words[i*8 +: 8] = words_q[i];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      feedback_div <= 6'h00;
    end else if (clock_enable) begin
      feedback_div <= fb_of(prescaler);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      store_request <= 1'b0;
      store_lock <= 1'b0;
      outputs_enabled <= 1'b0;
      readback_active <= 1'b0;
    end else if (clock_enable) begin
      store_request <= (state_q == spcp_pkg::SPCP_EE_STORE)
                       || (state_q == spcp_pkg::SPCP_EE_LOCK);
      store_lock <= (state_q == spcp_pkg::SPCP_EE_LOCK);
      outputs_enabled <= (state_q != spcp_pkg::SPCP_NORMAL)
                         || chip_enable;
      readback_active <= (state_q == spcp_pkg::SPCP_READBACK);
    end
  end

  assign state = state_q;
endmodule // spcp_device

// file: design/spcp_host.sv
// host end: sends pulse-coded bit sequences on the programming pin
`timescale 1ns/1ps
`include "spcp_params.svh"
module spcp_host (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        clock_enable,
  // link
  spcp_link_if.host        link,
  // user side request: bits sent lsb first, cmd_len bits
  input  wire logic        cmd_valid,
  input  wire logic [9:0]  cmd_bits,
  input  wire logic [3:0]  cmd_len,
  input  wire logic        cmd_is_store,
  output logic             cmd_ready,
  output logic             cmd_done
);
  typedef enum logic [1:0] {H_IDLE, H_SEND, H_WAIT} spcp_host_state_t;
  spcp_host_state_t st_q;
  logic [9:0]  sh_q;
  logic [3:0]  left_q;
  logic [17:0] cnt_q;
  logic        store_q;
  logic        pin_q;
  logic        done_q;

  assign cmd_ready = (st_q == H_IDLE);
  assign link.serial_program_pin = pin_q;
  assign cmd_done = done_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      st_q <= H_IDLE;
      sh_q <= 10'h000;
      left_q <= 4'h0;
      cnt_q <= 18'h00000;
      store_q <= 1'b0;
      pin_q <= 1'b0;
      done_q <= 1'b0;
    end else if (clock_enable) begin
      done_q <= 1'b0;
      case (st_q)
        H_IDLE: begin
          pin_q <= 1'b0;
          if (cmd_valid && cmd_len != 4'h0) begin
            st_q <= H_SEND;
            sh_q <= cmd_bits;
            left_q <= cmd_len;
            store_q <= cmd_is_store;
            cnt_q <= 18'h00000;
          end
        end
        H_SEND: begin
          // one pulse per period: high 0.2t for 0, 0.8t for 1
          pin_q <= (cnt_q < 18'(sh_q[0] ? `SPCP_LONG_CYC
                                         : `SPCP_SHORT_CYC));
          if (cnt_q == 18'(`SPCP_BIT_CYC - 1)) begin
            cnt_q <= 18'h00000;
            sh_q <= {1'b0, sh_q[9:1]};
            left_q <= left_q - 4'h1;
            if (left_q == 4'h1) begin
              st_q <= store_q ? H_WAIT : H_IDLE;
              done_q <= ~store_q;
            end
          end else begin
            cnt_q <= cnt_q + 18'h00001;
          end
        end
        H_WAIT: begin
          pin_q <= 1'b0;
          if (cnt_q == 18'(`SPCP_EE_WAIT_CYC - 1)) begin
            st_q <= H_IDLE;
            done_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 18'h00001;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end
endmodule // spcp_host

// file: tb/spcp_link_props.sv
// assertions on the programming pin and device outputs
`timescale 1ns/1ps
module spcp_link_props (
  // clock and reset
  input wire logic                  clock,
  input wire logic                  reset,
  input wire logic                  clock_enable,
  // link and device side
  input wire logic                  serial_program_pin,
  input wire logic [47:0]           config_words,
  input wire logic [5:0]            feedback_div,
  input wire logic [2:0]            prescaler,
  input wire spcp_pkg::spcp_state_t state,
  input wire logic                  outputs_enabled,
  input wire logic                  store_request,
  input wire logic                  store_lock,
  input wire logic                  readback_active
);
  logic [8:0] hi_q;
  logic [2:0] pre_q;
  // saturating, so a stuck pin cannot wrap back into range
  always_ff @(posedge clock)
    if (reset || !serial_program_pin) hi_q <= 9'h000;
    else if (clock_enable && hi_q != 9'h1FF) hi_q <= hi_q + 9'h001;
  // divider only follows the prescaler on enabled cycles
  always_ff @(posedge clock)
    if (clock_enable) pre_q <= prescaler;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  pulse_width_a: assert property (
    $fell(serial_program_pin) && !$past(reset) |->
      hi_q == 9'h047 || hi_q == 9'h11D) else $error("bad pulse width");
  pulse_max_a: assert property (
    hi_q <= 9'h11D) else $error("pulse too long");
  reset_state_a: assert property (disable iff (1'b0)
    reset |=> !serial_program_pin && state == spcp_pkg::SPCP_NORMAL
      && config_words == 48'h0) else $error("bad reset state");
  div_map_a: assert property (
    !$past(reset) |-> feedback_div == (pre_q == 3'h2 ? 6'h20 :
      pre_q == 3'h3 ? 6'h14 : pre_q == 3'h4 ? 6'h10 :
      pre_q == 3'h5 ? 6'h0C : 6'h00)) else $error("bad divider");
  ce_ignored_a: assert property (
    state != spcp_pkg::SPCP_NORMAL && $stable(state) |-> outputs_enabled)
    else $error("outputs off outside normal");
  lock_pair_a: assert property (
    store_lock |-> store_request) else $error("lock without store");
  readback_hold_a: assert property (
    readback_active |=> readback_active) else $error("readback dropped");
  word_gate_a: assert property (
    $changed(config_words) && !$past(reset) |->
      $past(state) == spcp_pkg::SPCP_PROG) else $error("word outside prog");
  state_edge_a: assert property (
    $changed(state) && !$past(reset) |->
      !serial_program_pin && !$past(serial_program_pin))
    else $error("state moved during pulse");
  cover property (state == spcp_pkg::SPCP_EE_STORE);
  cover property (state == spcp_pkg::SPCP_EE_LOCK);
  cover property (readback_active);
  cover property ($changed(config_words));
endmodule // spcp_link_props

// file: tb/tb_single_pin_config_programmer.sv
// random and corner stimulus through host end into device end
`timescale 1ns/1ps
module tb_single_pin_config_programmer;
  logic clock, reset, chip_enable, cmd_valid, cmd_ready, cmd_done;
  logic outputs_enabled, store_request, store_lock, readback_active;
  logic clock_enable, cmd_store;
  logic [2:0]  prescaler;
  logic [9:0]  cmd_bits;
  logic [3:0]  cmd_len;
  logic [47:0] config_words, exp_words;
  logic [5:0]  feedback_div;
  logic [7:0]  pay;
  int          errors, tests_run, i;
  spcp_pkg::spcp_state_t state;
  spcp_link_if link ();
  spcp_device i_spcp_device (.clock(clock), .reset(reset),
    .clock_enable(clock_enable), .link(link), .chip_enable(chip_enable),
    .prescaler(prescaler), .config_words(config_words),
    .feedback_div(feedback_div), .state(state),
    .outputs_enabled(outputs_enabled), .store_request(store_request),
    .store_lock(store_lock), .readback_active(readback_active));
  spcp_host i_spcp_host (.clock(clock), .reset(reset),
    .clock_enable(clock_enable), .link(link), .cmd_valid(cmd_valid),
    .cmd_bits(cmd_bits), .cmd_len(cmd_len), .cmd_is_store(cmd_store),
    .cmd_ready(cmd_ready), .cmd_done(cmd_done));
  spcp_link_props i_spcp_link_props (.clock(clock), .reset(reset),
    .clock_enable(clock_enable),
    .serial_program_pin(link.serial_program_pin),
    .config_words(config_words), .feedback_div(feedback_div),
    .prescaler(prescaler), .state(state),
    .outputs_enabled(outputs_enabled), .store_request(store_request),
    .store_lock(store_lock), .readback_active(readback_active));
  task automatic stop_test();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk_val(logic [47:0] got, logic [47:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_state(spcp_pkg::spcp_state_t exp);
    tests_run++;
    if (state !== exp) begin
      errors++;
      $display("[ERR] %0t state %0d expected %0d", $time, state, exp);
    end
  endtask
  task automatic cycles(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // bounded wait on the done pulse, then let the device settle
  task automatic send(logic [9:0] b, logic [3:0] n);
    int k;
    cmd_bits = b;
    cmd_len = n;
    cmd_valid = 1'b1;
    cycles(1);
    cmd_valid = 1'b0;
    for (k = 0; k < 4000; k++) begin
      cycles(1);
      if (cmd_done === 1'b1) break;
    end
    if (k == 4000) begin
      errors++;
      $display("[ERR] %0t command never finished", $time);
      stop_test();
    end
    cycles(8);
  endtask
  // wire order: selector lsb first; payload msb shares the third slot
  function automatic logic [9:0] wcmd(logic [2:0] s, logic [7:0] p);
    logic [9:0] c;
    c[2:0] = s;
    for (int j = 0; j < 8; j++) c[2+j] = p[7-j];
    return c;
  endfunction
  function automatic logic [5:0] fb(logic [2:0] p);
    case (p)
      3'h2: return 6'h20;
      3'h3: return 6'h14;
      3'h4: return 6'h10;
      3'h5: return 6'h0C;
      default: return 6'h00;
    endcase
  endfunction
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    reset = 1'b1;
    clock_enable = 1'b1;
    cmd_store = 1'b0;
    chip_enable = 1'b1;
    prescaler = 3'h2;
    cmd_valid = 1'b0;
    cmd_bits = 10'h000;
    cmd_len = 4'h0;
    errors = 0;
    tests_run = 0;
    exp_words = 48'h0;
    i = $urandom(54944);
    cycles(10);
    reset = 1'b0;
    chk_state(spcp_pkg::SPCP_NORMAL);
    chk_val(config_words, exp_words);
    for (i = 0; i < 8; i++) begin
      prescaler = i[2:0];
      cycles(2);
      chk_val(48'(feedback_div), 48'(fb(i[2:0])));
    end
    // enable low freezes the divider register
    clock_enable = 1'b0;
    prescaler = 3'h3;
    cycles(2);
    chk_val(48'(feedback_div), 48'(fb(3'h7)));
    clock_enable = 1'b1;
    cycles(2);
    chk_val(48'(feedback_div), 48'(fb(3'h3)));
    send(10'h037, 4'h6);
    chk_state(spcp_pkg::SPCP_READBACK);
    chk_val(48'(readback_active), 48'h1);
    reset = 1'b1;
    cycles(1);
    reset = 1'b0;
    send(10'h00C, 4'h6);
    chk_state(spcp_pkg::SPCP_PROG);
    chip_enable = 1'b0;
    cycles(2);
    chk_val(48'(outputs_enabled), 48'h1);
    for (i = 0; i < 6; i++) begin
      pay = 8'($urandom);
      pay[7] = i[2];
      exp_words[8*i +: 8] = pay;
      send(wcmd(i[2:0], pay), 4'hA);
      chk_val(config_words, exp_words);
    end
    pay = 8'($urandom);
    pay[7] = 1'b0;
    send(wcmd(3'h2, pay), 4'h5);
    cycles(900);
    chk_val(config_words, exp_words);
    exp_words[23:16] = pay;
    send(wcmd(3'h2, pay) >> 5, 4'h5);
    chk_val(config_words, exp_words);
    send(wcmd(3'h7, 8'hA5), 4'hA);
    chk_state(spcp_pkg::SPCP_NORMAL);
    chk_val(48'(outputs_enabled), 48'h0);
    chip_enable = 1'b1;
    send(10'h00C, 4'h6);
    chk_state(spcp_pkg::SPCP_PROG);
    // jump payload msb rides in the third selector slot, so it is 1;
    // exit follows the lock at once, no store time is modelled here
    send(wcmd(3'h7, 8'hD5), 4'hA);
    chk_state(spcp_pkg::SPCP_EE_LOCK);
    chk_val(48'({store_request, store_lock}), 48'h3);
    send(wcmd(3'h7, 8'h80), 4'hA);
    chk_state(spcp_pkg::SPCP_NORMAL);
    chk_val(config_words, exp_words);
    send(10'h00C, 4'h6);
    // store jump: host holds off for the store time after the frame
    cmd_store = 1'b1;
    cmd_bits = wcmd(3'h7, 8'hF0);
    cmd_len = 4'hA;
    cmd_valid = 1'b1;
    cycles(1);
    cmd_valid = 1'b0;
    cycles(4000);
    chk_state(spcp_pkg::SPCP_EE_STORE);
    chk_val(48'({store_request, store_lock}), 48'h2);
    chk_val(48'({cmd_ready, cmd_done}), 48'h0);
    // the full hold would outlast the run, so a reset cuts it short
    reset = 1'b1;
    cmd_store = 1'b0;
    cycles(1);
    reset = 1'b0;
    chk_state(spcp_pkg::SPCP_NORMAL);
    chk_val(48'({cmd_ready, config_words == 48'h0}), 48'h3);
    stop_test();
  end
endmodule // tb_single_pin_config_programmer
